/* File: hw/dpr_defines.svh */
// Offsets, field positions, reset values and constants of the power requestor.
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// Number of power domains served; also reported in the configuration register.
`define DPR_NUM_REQ 8
`define DPR_NUM_REQ_FIELD 6'd8

// Word offsets, as byte addresses within the 4KB block.
`define DPR_OFF_REQ 12'h000
`define DPR_OFF_ACK 12'h004
`define DPR_OFF_INTEGRATION_MODE_CONTROL 12'hf00
`define DPR_OFF_CLAIM_TAG_SET 12'hfa0
`define DPR_OFF_CLAIM_TAG_CLEAR 12'hfa4
`define DPR_OFF_LOCKKEY 12'hfb0
`define DPR_OFF_LOCKSTATE 12'hfb4
`define DPR_OFF_AUTH 12'hfb8
`define DPR_OFF_ARCH 12'hfbc
`define DPR_OFF_CONFIG 12'hfc8
`define DPR_OFF_TYPE 12'hfcc
`define DPR_OFF_PID4 12'hfd0
`define DPR_OFF_PID5 12'hfd4
`define DPR_OFF_PID6 12'hfd8
`define DPR_OFF_PID7 12'hfdc
`define DPR_OFF_PID0 12'hfe0
`define DPR_OFF_PID1 12'hfe4
`define DPR_OFF_PID2 12'hfe8
`define DPR_OFF_PID3 12'hfec
`define DPR_OFF_CID0 12'hff0
`define DPR_OFF_CID1 12'hff4
`define DPR_OFF_CID2 12'hff8
`define DPR_OFF_CID3 12'hffc

// Field positions.
`define DPR_CFG_COUNT_LSB 0
`define DPR_CFG_COUNT_MSB 5
`define DPR_INTEGRATION_MODE_CONTROL_BIT 0
`define DPR_CLAIM_BITS 4
`define DPR_CLAIM_IMPL 4'hf

// Reset values.
`define DPR_REQ_RESET 8'h00
`define DPR_CLAIM_RESET 4'h0
`define DPR_INTEGRATION_MODE_CONTROL_RESET 1'b0

// A hidden shared domain is powered whenever any of its users is requested.
`define DPR_LINK_DOMAIN 3'd7
`define DPR_LINK_USERS 8'h03

// Identification values; the designer, part and architecture codes are arbitrary.
`define DPR_ARCH_VALUE 32'h2461_0b12
`define DPR_TYPE_MAJOR 4'h4
`define DPR_TYPE_SUB 4'h3
`define DPR_PID0 8'h5a
`define DPR_PID1 8'hb1
`define DPR_PID2 8'h0c
`define DPR_PID3 8'h00
`define DPR_PID4 8'h01
`define DPR_PID5 8'h00
`define DPR_PID6 8'h00
`define DPR_PID7 8'h00
`define DPR_CID0 8'h0d
`define DPR_CID1_CLASS 4'h9
`define DPR_CID1_LOW 4'h0
`define DPR_CID2 8'h05
`define DPR_CID3 8'hb1

`endif

/* File: hw/dpr_pkg.sv */
// Types shared by the power requestor design and its bench.
`include "dpr_defines.svh"

package dpr_pkg;

	typedef logic [`DPR_NUM_REQ-1:0] dpr_domains_t;

	// One register access from software.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} dpr_bus_req_t;

	// All state of the power requestor except the two reset synchroniser flip-flops.
	typedef struct packed {
		dpr_domains_t req;
		dpr_domains_t pwr_out;
		dpr_domains_t ack_meta;
		dpr_domains_t ack_sync;
		logic [`DPR_CLAIM_BITS-1:0] claim;
		logic integration_mode_control;
		logic [31:0] rdata;
	} dpr_state_t;

endpackage

/* File: hw/dpr_top.sv */
// Debug power requestor: request, acknowledge and identification registers.
//
// Function
// RULE1: Request bit n drives domain n power.
// RULE2: Request bits beyond count read zero, ignore writes.
// RULE3: Read-only acknowledge register mirrors domain status.
// RULE4: Acknowledge bit one means domain is powered.
// RULE5: Acknowledge bits beyond count read zero.
// RULE6: Configuration register reports request count, rest zero.
// RULE7: Architecture register returns fixed identifying constant.
// RULE8: Type register returns major four, sub three.
// RULE9: Component ID byte one upper nibble nine.
// RULE10: Peripheral ID fields are fixed implementation constants.
// RULE11: Shared hidden domain powered with its users.
// RULE12: Registers in 4KB block, request 0x000, acknowledge 0x004.
// RULE13: Level request out, synchronised level acknowledge in.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "dpr_defines.svh"

module dpr_top (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Register port.
	input wire dpr_pkg::dpr_bus_req_t REG_REQ,
	output logic [31:0] REG_RDATA,
	// Power controllers.
	output dpr_pkg::dpr_domains_t PWR_REQ,
	input wire dpr_pkg::dpr_domains_t PWR_ACK
);

	logic rst_meta_q;
	logic rst_sync_n_q;
	dpr_pkg::dpr_state_t st_q;
	dpr_pkg::dpr_state_t st_d;

	// Adds the shared hidden domain to whatever its users request.
	function automatic dpr_pkg::dpr_domains_t with_linked(
		input dpr_pkg::dpr_domains_t r
	);
		dpr_pkg::dpr_domains_t o;
		o = r;
		if ((r & `DPR_LINK_USERS) != '0) begin
			o[`DPR_LINK_DOMAIN] = 1'b1; // RULE11
		end
		return o;
	endfunction

	// Value returned for a read at the given byte address.
	function automatic logic [31:0] read_value(
		input logic [11:0] a,
		input dpr_pkg::dpr_state_t s
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case ({a[11:2], 2'b00})
			`DPR_OFF_REQ: v[`DPR_NUM_REQ-1:0] = s.req; // RULE2
			`DPR_OFF_ACK: v[`DPR_NUM_REQ-1:0] = s.ack_sync; // RULE3 RULE5
			`DPR_OFF_INTEGRATION_MODE_CONTROL: v[`DPR_INTEGRATION_MODE_CONTROL_BIT] = s.integration_mode_control;
			`DPR_OFF_CLAIM_TAG_SET: v[`DPR_CLAIM_BITS-1:0] = `DPR_CLAIM_IMPL;
			`DPR_OFF_CLAIM_TAG_CLEAR: v[`DPR_CLAIM_BITS-1:0] = s.claim;
			`DPR_OFF_ARCH: v = `DPR_ARCH_VALUE; // RULE7
			`DPR_OFF_CONFIG: begin
				v[`DPR_CFG_COUNT_MSB:`DPR_CFG_COUNT_LSB] =
					`DPR_NUM_REQ_FIELD; // RULE6
			end
			`DPR_OFF_TYPE: v[7:0] = {`DPR_TYPE_SUB, `DPR_TYPE_MAJOR}; // RULE8
			`DPR_OFF_PID0: v[7:0] = `DPR_PID0; // RULE10
			`DPR_OFF_PID1: v[7:0] = `DPR_PID1; // RULE10
			`DPR_OFF_PID2: v[7:0] = `DPR_PID2; // RULE10
			`DPR_OFF_PID3: v[7:0] = `DPR_PID3; // RULE10
			`DPR_OFF_PID4: v[7:0] = `DPR_PID4; // RULE10
			`DPR_OFF_PID5: v[7:0] = `DPR_PID5;
			`DPR_OFF_PID6: v[7:0] = `DPR_PID6;
			`DPR_OFF_PID7: v[7:0] = `DPR_PID7;
			`DPR_OFF_CID0: v[7:0] = `DPR_CID0;
			`DPR_OFF_CID1: v[7:0] = {`DPR_CID1_CLASS, `DPR_CID1_LOW}; // RULE9
			`DPR_OFF_CID2: v[7:0] = `DPR_CID2;
			`DPR_OFF_CID3: v[7:0] = `DPR_CID3;
			default: v = 32'h0000_0000; // RULE12
		endcase
		return v;
	endfunction

	// Reset is released through two flip-flops.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	always_comb begin
		st_d = st_q;
		// The first acknowledge stage feeds only the second.
		st_d.ack_meta = PWR_ACK; // RULE13
		st_d.ack_sync = st_q.ack_meta; // RULE4 RULE13
		st_d.rdata = 32'h0000_0000;
		if (REG_REQ.rd) begin
			st_d.rdata = read_value(REG_REQ.addr, st_q);
		end
		if (REG_REQ.wr) begin
			case ({REG_REQ.addr[11:2], 2'b00})
				`DPR_OFF_REQ: begin
					st_d.req = REG_REQ.wdata[`DPR_NUM_REQ-1:0]; // RULE1 RULE2
				end
				`DPR_OFF_INTEGRATION_MODE_CONTROL: begin
					st_d.integration_mode_control = REG_REQ.wdata[`DPR_INTEGRATION_MODE_CONTROL_BIT];
				end
				`DPR_OFF_CLAIM_TAG_SET: begin
					st_d.claim = st_q.claim |
						REG_REQ.wdata[`DPR_CLAIM_BITS-1:0];
				end
				`DPR_OFF_CLAIM_TAG_CLEAR: begin
					st_d.claim = st_q.claim &
						~REG_REQ.wdata[`DPR_CLAIM_BITS-1:0];
				end
				default: begin
					st_d.req = st_q.req; // RULE12
				end
			endcase
		end
		st_d.pwr_out = with_linked(st_q.req); // RULE1 RULE11 RULE13
	end

	always_ff @(posedge CORE_CLK or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			st_q.req <= `DPR_REQ_RESET;
			st_q.pwr_out <= `DPR_REQ_RESET;
			st_q.ack_meta <= '0;
			st_q.ack_sync <= '0;
			st_q.claim <= `DPR_CLAIM_RESET;
			st_q.integration_mode_control <= `DPR_INTEGRATION_MODE_CONTROL_RESET;
			st_q.rdata <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
		end
	end

	assign REG_RDATA = st_q.rdata;
	assign PWR_REQ = st_q.pwr_out;

endmodule

/* File: sim/dpr_checker.sv */
// Assertions on the power requestor's register and power ports.
`timescale 1ns/1ps
module dpr_checker (
	// Clock, reset and ports watched.
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire dpr_pkg::dpr_bus_req_t REG_REQ,
	input wire logic [31:0] REG_RDATA,
	input wire dpr_pkg::dpr_domains_t PWR_REQ,
	input wire dpr_pkg::dpr_domains_t PWR_ACK
);
	wire logic rd = REG_REQ.rd;
	wire logic [9:0] ra = REG_REQ.addr[11:2];
	wire logic w0 = REG_REQ.wr && ra == 10'h000;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	chk_rdata_idle:
	assert property (!$past(rd) |-> REG_RDATA == 32'h0) else $error("idle");
	chk_req_write:
	assert property ($past(w0, 2) |-> PWR_REQ[6:0] ==
		$past(REG_REQ.wdata[6:0], 2)) else $error("req out");
	chk_req_hold:
	assert property ($changed(PWR_REQ) |-> $past(w0, 2)) else $error("hold");
	chk_link_dom:
	assert property (|PWR_REQ[1:0] |-> PWR_REQ[7]) else $error("link");
	chk_ack_read:
	assert property ($past(rd && ra == 10'h001) |->
		REG_RDATA == {24'h0, $past(PWR_ACK, 3)}) else $error("ack");
	chk_req_width:
	assert property ($past(rd && ra == 10'h000) |->
		REG_RDATA[31:8] == 24'h0) else $error("width");
	chk_cfg_read:
	assert property ($past(rd && ra == 10'h3f2) |->
		REG_RDATA == 32'h8) else $error("cfg");
	chk_type_read:
	assert property ($past(rd && ra == 10'h3f3) |->
		REG_RDATA == 32'h34) else $error("type");
	chk_cid_class:
	assert property ($past(rd && ra == 10'h3fd) |->
		REG_RDATA[7:4] == 4'h9) else $error("class");
endmodule

/* File: sim/dpr_pwr_model.sv */
// Behavioural power controllers answering each domain's request level.
`timescale 1ns/1ps
module dpr_pwr_model (
	// Clock and pace.
	input wire logic clk,
	input wire logic slow,
	// Request and acknowledge levels.
	input wire dpr_pkg::dpr_domains_t req,
	output dpr_pkg::dpr_domains_t ack
);
	dpr_pkg::dpr_domains_t h [4];
	always @(posedge clk) begin
		h <= '{req, h[0], h[1], h[2]};
	end
	// A slow controller takes four cycles to power a domain up or down.
	assign ack = slow ? h[3] : h[0];
endmodule

/* File: sim/tb_dpr_top.sv */
// Self-checking bench for the debug power requestor.
`timescale 1ns/1ps
module tb_dpr_top;
	logic CORE_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic slow = 1'b0;
	dpr_pkg::dpr_bus_req_t REG_REQ = '0;
	logic [31:0] REG_RDATA;
	dpr_pkg::dpr_domains_t PWR_REQ;
	dpr_pkg::dpr_domains_t PWR_ACK;
	dpr_pkg::dpr_domains_t e = '0;
	logic [31:0] exp_q [$];
	logic [31:0] d;
	logic rd_d = 1'b0;
	int failures = 0;
	int n_tests = 0;
	logic [11:0] ta [6] = '{12'hfc8, 12'hfcc, 12'hff4, 12'hfbc, 12'h8, 12'hefc};
	logic [31:0] tv [6] = '{32'h8, 32'h34, 32'h90, 32'h24610b12, 32'h0, 32'h0};
	always #10 CORE_CLK = ~CORE_CLK;
	dpr_top uut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_REQ(REG_REQ),
		.REG_RDATA(REG_RDATA), .PWR_REQ(PWR_REQ), .PWR_ACK(PWR_ACK));
	dpr_pwr_model pwr (.clk(CORE_CLK), .slow(slow), .req(PWR_REQ),
		.ack(PWR_ACK));
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			failures++;
			$display("[ERR] %0t %h %h", $time, s, x);
		end
	endtask
	// Value v is write data for a write and the expected answer for a read.
	task op(input logic w, input logic r, input logic [11:0] a,
		input logic [31:0] v);
		@(posedge CORE_CLK);
		REG_REQ <= '{w, r, a, w ? v : 32'h0};
		if (r) exp_q.push_back(v);
	endtask
	task summarize();
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		rd_d <= REG_REQ.rd;
		if (rd_d) chk(REG_RDATA, exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'ha9a41d8e));
		repeat (2) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		repeat (4) @(posedge CORE_CLK);
		op(1, 0, 12'hfc8, 32'hffffffff);
		for (int i = 0; i < 6; i++) op(0, 1, ta[i], tv[i]);
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			slow <= i[0];
			op(1, 0, 12'h000, d);
			op(0, 1, 12'h000, {24'h0, d[7:0]});
			// The new request has not been acknowledged yet.
			op(0, 1, 12'h004, {24'h0, e});
			op(0, 0, 12'h000, 32'h0);
			e = d[7:0] | {|d[1:0], 7'h0};
			repeat (2) @(posedge CORE_CLK);
			chk({24'h0, PWR_REQ}, {24'h0, e});
			repeat (10) @(posedge CORE_CLK);
			op(0, 1, 12'h004, {24'h0, e});
		end
		op(0, 0, 12'h000, 32'h0);
		repeat (3) @(posedge CORE_CLK);
		summarize();
	end
endmodule
bind dpr_top dpr_checker chk_i (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
	.REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .PWR_REQ(PWR_REQ),
	.PWR_ACK(PWR_ACK));
